// ===== fast_buffered_remote_write.sv
// fast_buffered_remote_write: remote write arbitration state machine
// assumes: clk_sys is the cpu clock, one T-state per cycle; remote pins asynchronous
`timescale 1ns/1ps
`default_nettype none
module fast_buffered_remote_write (
  input  wire logic        clk_sys,
  input  wire logic        resetn,
  input  wire logic        remote_access_enable,
  input  wire logic        remote_write_strobe_n,
  input  wire logic        cmd_select,
  input  wire logic        wait_n,
  input  wire logic        bus_lock_n,
  input  wire logic        local_bus_request,
  input  wire logic        local_write_active,
  input  wire logic [7:0]  ad_in,
  input  wire logic [7:0]  device_config_reg,
  output logic             local_bus_grant,
  output logic             tcu_wait,
  output logic             transfer_ack,
  output logic             local_bus_owner_n,
  output logic             bus_oe,
  output logic             mem_write_n,
  output logic             instr_mem_write_n,
  output logic [15:0]      instr_word,
  output logic [7:0]       remote_interface_config,
  output logic [7:0]       active_config,
  output logic [15:0]      program_counter,
  output logic             high_instr_byte_flag,
  output logic [1:0]       memory_select_field,
  output logic             lock_out_remote
);
  // ----------------------------------------------------------------
  // input synchronisers
  // ----------------------------------------------------------------
  logic rae_s;
  logic wr_n_s;
  logic wait_n_s;
  logic req;

  fbw_sync u_sync_rae (
    .clk_sys   (clk_sys),
    .resetn    (resetn),
    .async_in  (remote_access_enable),
    .reset_val (1'b0),
    .sync_out  (rae_s)
  );
  fbw_sync u_sync_wr (
    .clk_sys   (clk_sys),
    .resetn    (resetn),
    .async_in  (~remote_write_strobe_n),
    .reset_val (1'b0),
    .sync_out  (wr_n_s)
  );
  fbw_sync u_sync_wait (
    .clk_sys   (clk_sys),
    .resetn    (resetn),
    .async_in  (~wait_n),
    .reset_val (1'b0),
    .sync_out  (wait_n_s)
  );
  assign req = rae_s & wr_n_s;

  // ----------------------------------------------------------------
  // state and counters
  // ----------------------------------------------------------------
  fbw_pkg::fsm_state_t state_reg;
  fbw_pkg::fsm_state_t state_next;
  logic [2:0]  wait_cnt_reg;
  logic [7:0]  instr_low_byte_holder;
  logic        took_high_reg;
  logic        was_instruction_memory_reg;
  logic        cfg_pend_reg;
  logic        waits_done;
  logic        idle_state;
  logic        take_delay_reg;
  logic        take_ok;

  assign lock_out_remote     = active_config[fbw_pkg::cfg_lor_bit];
  assign memory_select_field = active_config[fbw_pkg::cfg_ms_lsb +: 2];
  assign idle_state          = (state_reg == fbw_pkg::st_idle1) ||
                               (state_reg == fbw_pkg::st_idle2);
  assign waits_done          = (wait_cnt_reg == 3'h0) && !wait_n_s;
  assign take_ok             = !local_bus_request && !local_write_active &&
                               !take_delay_reg;

  always_comb begin
    state_next = state_reg;
    case (state_reg)
      fbw_pkg::st_idle1: begin
        if (req && (lock_out_remote || local_bus_grant)) begin
          state_next = fbw_pkg::st_idle2;
        end else if (req && take_ok) begin
          state_next = fbw_pkg::st_take;
        end
      end
      fbw_pkg::st_idle2: begin
        if (!req) begin
          state_next = fbw_pkg::st_idle1;
        end else if (!lock_out_remote && !local_bus_grant && take_ok) begin
          state_next = fbw_pkg::st_take;
        end
      end
      fbw_pkg::st_take: state_next = fbw_pkg::st_own;
      fbw_pkg::st_own: begin
        if (cmd_select) begin
          state_next = fbw_pkg::st_cfg;
        end else begin
          case (memory_select_field)
            fbw_pkg::ms_pc_lo: state_next = fbw_pkg::st_pc_lo;
            fbw_pkg::ms_pc_hi: state_next = fbw_pkg::st_pc_hi;
            fbw_pkg::ms_data_memory:  state_next = fbw_pkg::st_data_memory;
            default: begin
              state_next = high_instr_byte_flag ? fbw_pkg::st_ihigh
                                                : fbw_pkg::st_ilow;
            end
          endcase
        end
      end
      fbw_pkg::st_cfg,
      fbw_pkg::st_pc_lo,
      fbw_pkg::st_pc_hi,
      fbw_pkg::st_data_memory,
      fbw_pkg::st_ilow,
      fbw_pkg::st_ihigh: begin
        if (waits_done) begin
          state_next = fbw_pkg::st_term;
        end
      end
      fbw_pkg::st_term:    state_next = fbw_pkg::st_release;
      fbw_pkg::st_release: state_next = req ? fbw_pkg::st_extra
                                            : fbw_pkg::st_idle1;
      fbw_pkg::st_extra: begin
        if (!req) begin
          state_next = fbw_pkg::st_idle1;
        end
      end
      default: state_next = fbw_pkg::st_idle1;
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      state_reg <= fbw_pkg::st_idle1;
    end else begin
      state_reg <= state_next;
    end
  end

  // one T-state guard after a local write before the bus changes hands
  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      take_delay_reg <= 1'b0;
    end else begin
      take_delay_reg <= local_write_active;
    end
  end

  // wait counter: loaded on ownership, counts down in access states
  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      wait_cnt_reg <= 3'h0;
    end else if (state_reg == fbw_pkg::st_take) begin
      if (memory_select_field == fbw_pkg::ms_instruction_memory && !cmd_select) begin
        wait_cnt_reg <= {1'b0, device_config_reg[fbw_pkg::dcr_iw_lsb +: 2]};
      end else if (memory_select_field == fbw_pkg::ms_data_memory && !cmd_select) begin
        wait_cnt_reg <= device_config_reg[fbw_pkg::dcr_dw_lsb +: 3];
      end else begin
        wait_cnt_reg <= 3'h0;
      end
    end else if (state_reg != fbw_pkg::st_own && wait_cnt_reg != 3'h0) begin
      wait_cnt_reg <= wait_cnt_reg - 3'h1;
    end
  end

  // ----------------------------------------------------------------
  // handshake and bus control
  // ----------------------------------------------------------------
  always_comb begin
    transfer_ack = 1'b1;
    if (idle_state && req) begin
      transfer_ack = 1'b0;
    end else if (!idle_state && state_reg != fbw_pkg::st_term &&
                 state_reg != fbw_pkg::st_release && state_reg != fbw_pkg::st_extra) begin
      transfer_ack = 1'b0;
    end
  end

  // local grants only while the remote side is off the buses
  always_comb begin
    local_bus_grant = 1'b0;
    case (state_reg)
      fbw_pkg::st_idle1,
      fbw_pkg::st_idle2: begin
        local_bus_grant = local_bus_request && bus_lock_n;
      end
      fbw_pkg::st_release,
      fbw_pkg::st_extra: begin
        local_bus_grant = local_bus_request && bus_lock_n;
      end
      default: begin
        local_bus_grant = 1'b0;
      end
    endcase
  end

  always_comb begin
    tcu_wait = 1'b0;
    if (local_bus_request && !local_bus_grant && !idle_state &&
        state_reg != fbw_pkg::st_term) begin
      tcu_wait = 1'b1;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      local_bus_owner_n <= 1'b0;
      bus_oe            <= 1'b1;
    end else begin
      local_bus_owner_n <= (state_next != fbw_pkg::st_idle1) &&
                           (state_next != fbw_pkg::st_idle2) &&
                           (state_next != fbw_pkg::st_take) &&
                           (state_next != fbw_pkg::st_release) &&
                           (state_next != fbw_pkg::st_extra);
      bus_oe            <= (state_next == fbw_pkg::st_idle1) ||
                           (state_next == fbw_pkg::st_idle2);
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      mem_write_n       <= 1'b1;
      instr_mem_write_n <= 1'b1;
    end else begin
      mem_write_n       <= !(state_next == fbw_pkg::st_data_memory);
      instr_mem_write_n <= !((state_next == fbw_pkg::st_ihigh) ||
                             (state_next == fbw_pkg::st_own && !cmd_select &&
                              memory_select_field == fbw_pkg::ms_instruction_memory &&
                              high_instr_byte_flag));
    end
  end

  // ----------------------------------------------------------------
  // data paths
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      instr_low_byte_holder <= 8'h00;
      instr_word            <= 16'h0000;
    end else if (state_next == fbw_pkg::st_ilow && state_reg == fbw_pkg::st_own) begin
      instr_low_byte_holder <= ad_in;
    end else if (state_next == fbw_pkg::st_ihigh && state_reg == fbw_pkg::st_own) begin
      instr_word            <= {ad_in, instr_low_byte_holder};
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      remote_interface_config <= fbw_pkg::cfg_reset;
      cfg_pend_reg            <= 1'b0;
    end else if (state_next == fbw_pkg::st_cfg && state_reg == fbw_pkg::st_own) begin
      remote_interface_config <= ad_in;
      cfg_pend_reg            <= 1'b1;
    end else if (state_reg == fbw_pkg::st_release) begin
      cfg_pend_reg            <= 1'b0;
    end
  end

  // mode change applies one T-state after the write completes
  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      active_config <= fbw_pkg::cfg_reset;
    end else if (cfg_pend_reg && state_reg == fbw_pkg::st_release) begin
      active_config <= remote_interface_config;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      was_instruction_memory_reg  <= 1'b0;
      took_high_reg <= 1'b0;
    end else if (state_reg == fbw_pkg::st_own) begin
      was_instruction_memory_reg  <= (state_next == fbw_pkg::st_ilow) || (state_next == fbw_pkg::st_ihigh);
      took_high_reg <= (state_next == fbw_pkg::st_ihigh);
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      high_instr_byte_flag <= 1'b0;
    end else if (state_next == fbw_pkg::st_cfg && state_reg == fbw_pkg::st_own &&
                 ad_in[fbw_pkg::cfg_ms_lsb +: 2] == fbw_pkg::ms_instruction_memory) begin
      high_instr_byte_flag <= 1'b0;
    end else if (state_reg == fbw_pkg::st_term && was_instruction_memory_reg) begin
      high_instr_byte_flag <= !high_instr_byte_flag;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      program_counter <= 16'h0000;
    end else if (state_next == fbw_pkg::st_pc_lo && state_reg == fbw_pkg::st_own) begin
      program_counter[7:0] <= ad_in;
    end else if (state_next == fbw_pkg::st_pc_hi && state_reg == fbw_pkg::st_own) begin
      program_counter[15:8] <= ad_in;
    end else if (state_reg == fbw_pkg::st_term && was_instruction_memory_reg && took_high_reg) begin
      program_counter <= program_counter + 16'h0001;
    end
  end
endmodule : fast_buffered_remote_write
`default_nettype wire

// ===== fbw_assertions.sv
// fbw_assertions: port-level checks for fast_buffered_remote_write
// assumes: bound to the design top, one clk_sys domain, sync reset
`timescale 1ns/1ps
`default_nettype none
module fbw_assertions (
  input wire logic clk_sys,
  input wire logic resetn,
  input wire logic local_bus_request,
  input wire logic local_write_active,
  input wire logic bus_lock_n,
  input wire logic local_bus_grant,
  input wire logic tcu_wait,
  input wire logic transfer_ack,
  input wire logic local_bus_owner_n,
  input wire logic bus_oe,
  input wire logic mem_write_n,
  input wire logic high_instr_byte_flag,
  input wire logic lock_out_remote
);
  // ----------------------------------------
  // arbitration and access phase
  // ----------------------------------------
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!resetn);
  a_grant_lock: assert property (local_bus_grant |-> bus_lock_n)
    else $error("local grant with bus lock low");
  a_no_grant_owned: assert property (local_bus_owner_n && !transfer_ack |-> !local_bus_grant)
    else $error("local grant during remote access");
  a_stall_owned: assert property (local_bus_owner_n && !transfer_ack && local_bus_request |-> tcu_wait)
    else $error("timing unit not stalled");
  a_takeover_owner: assert property ($fell(bus_oe) |=> local_bus_owner_n)
    else $error("owner not high after bus release");
  a_owner_ack: assert property ($rose(local_bus_owner_n) |-> !transfer_ack)
    else $error("ack high when remote takes bus");
  a_take_after_lw: assert property ($fell(bus_oe) |-> !$past(local_write_active))
    else $error("bus taken during local write");
  a_strobe_owned: assert property (!mem_write_n |-> local_bus_owner_n && !bus_oe)
    else $error("strobe low without remote ownership");
  a_ack_strobe: assert property ($rose(mem_write_n) |-> transfer_ack)
    else $error("strobe and ack not rising together");
  a_owner_release: assert property ($rose(transfer_ack) && local_bus_owner_n |=> !local_bus_owner_n)
    else $error("owner not released after termination");
  a_flag_reset: assert property ($rose(resetn) |-> !high_instr_byte_flag)
    else $error("byte flag set after reset");
  a_lockout_hold: assert property (lock_out_remote |-> !local_bus_owner_n)
    else $error("remote owns bus under lock-out");
endmodule : fbw_assertions
bind fast_buffered_remote_write fbw_assertions u_chk (
  .clk_sys              (clk_sys),
  .resetn               (resetn),
  .local_bus_request    (local_bus_request),
  .local_write_active   (local_write_active),
  .bus_lock_n           (bus_lock_n),
  .local_bus_grant      (local_bus_grant),
  .tcu_wait             (tcu_wait),
  .transfer_ack         (transfer_ack),
  .local_bus_owner_n    (local_bus_owner_n),
  .bus_oe               (bus_oe),
  .mem_write_n          (mem_write_n),
  .high_instr_byte_flag (high_instr_byte_flag),
  .lock_out_remote      (lock_out_remote)
);
`default_nettype wire

// ===== fbw_pkg.sv
// fbw_pkg: constants and state codes for the fast buffered remote write block
// assumes: single 10 MHz clk_sys, one T-state per clock
package fbw_pkg;
  typedef enum logic [3:0] {
    st_idle1   = 4'h0,
    st_idle2   = 4'h1,
    st_take    = 4'h2,
    st_own     = 4'h3,
    st_cfg     = 4'h4,
    st_pc_lo   = 4'h5,
    st_pc_hi   = 4'h6,
    st_data_memory    = 4'h7,
    st_ilow    = 4'h8,
    st_ihigh   = 4'h9,
    st_term    = 4'ha,
    st_release = 4'hb,
    st_extra   = 4'hc
  } fsm_state_t;
  localparam logic [1:0] ms_data_memory     = 2'h0;
  localparam logic [1:0] ms_instruction_memory     = 2'h1;
  localparam logic [1:0] ms_pc_lo    = 2'h2;
  localparam logic [1:0] ms_pc_hi    = 2'h3;
  localparam int         cfg_ms_lsb  = 0;
  localparam int         cfg_lor_bit = 2;
  localparam logic [7:0] cfg_reset   = 8'h00;
  localparam int         dcr_dw_lsb  = 0;
  localparam int         dcr_iw_lsb  = 3;
  localparam int         sync_depth  = 3;
endpackage : fbw_pkg

// ===== fbw_remote_host.sv
// fbw_remote_host: remote processor issuing one buffered write per go
// assumes: same clk_sys as the device, go held until done rises
`timescale 1ns/1ps
`default_nettype none
module fbw_remote_host (
  input  wire logic       clk_sys,
  input  wire logic       resetn,
  input  wire logic       go,
  input  wire logic       cmd,
  input  wire logic [7:0] data,
  input  wire logic [3:0] ext,
  input  wire logic       transfer_ack,
  output var logic        remote_access_enable = 1'b0,
  output var logic        remote_write_strobe_n = 1'b1,
  output var logic        cmd_select = 1'b0,
  output var logic [7:0]  ad_in = 8'h00,
  output var logic        wait_n = 1'b1,
  output var logic        done = 1'b0
);
  // ----------------------------------------
  // write cycle
  // ----------------------------------------
  logic       busy = 1'b0;
  logic       seen_low = 1'b0;
  logic [3:0] wcnt = 4'h0;
  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      remote_access_enable <= 1'b0;
      remote_write_strobe_n <= 1'b1;
      wait_n <= 1'b1;
      busy <= 1'b0;
      done <= 1'b0;
    end else if (!busy) begin
      done <= done & go;
      if (go && !done) begin
        remote_access_enable <= 1'b1;
        remote_write_strobe_n <= 1'b0;
        cmd_select <= cmd;
        ad_in <= data;
        wait_n <= (ext == 4'h0);
        wcnt <= ext;
        seen_low <= 1'b0;
        busy <= 1'b1;
      end
    end else begin
      if (wcnt != 4'h0) wcnt <= wcnt - 4'h1;
      if (wcnt <= 4'h1) wait_n <= 1'b1;
      if (!transfer_ack) seen_low <= 1'b1;
      if ((seen_low && transfer_ack) || !go) begin
        remote_access_enable <= 1'b0;
        remote_write_strobe_n <= 1'b1;
        cmd_select <= ~cmd_select;
        ad_in <= ~ad_in;
        wait_n <= 1'b1;
        busy <= 1'b0;
        done <= go;
      end
    end
  end
endmodule : fbw_remote_host
`default_nettype wire

// ===== fbw_sync.sv
// fbw_sync: three-stage input synchroniser with agreement filter
// assumes: input is asynchronous to clk_sys
`timescale 1ns/1ps
`default_nettype none
module fbw_sync (
  input  wire logic clk_sys,
  input  wire logic resetn,
  input  wire logic async_in,
  input  wire logic reset_val,
  output logic      sync_out
);
  logic [fbw_pkg::sync_depth-1:0] stage_reg;
  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      stage_reg <= {fbw_pkg::sync_depth{reset_val}};
    end else begin
      stage_reg <= {stage_reg[fbw_pkg::sync_depth-2:0], async_in};
    end
  end
  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      sync_out <= reset_val;
    end else if (stage_reg[1] == stage_reg[2]) begin
      sync_out <= stage_reg[2];
    end
  end
endmodule : fbw_sync
`default_nettype wire

// ===== test_fast_buffered_remote_write.sv
// test_fast_buffered_remote_write: directed tests of the remote write path
// assumes: fbw_remote_host as far side, design files compiled first
`timescale 1ns/1ps
`default_nettype none
module test_fast_buffered_remote_write;
  logic        clk_sys;
  logic        resetn = 1'b0;
  logic        bus_lock_n = 1'b1;
  logic        local_bus_request = 1'b0;
  logic        local_write_active = 1'b0;
  logic [7:0]  device_config_reg = 8'h02;
  logic        go = 1'b0;
  logic        cmd = 1'b0;
  logic [7:0]  data = 8'h00;
  logic [3:0]  ext = 4'h0;
  logic        remote_access_enable, remote_write_strobe_n, cmd_select, wait_n, done;
  logic [7:0]  ad_in, remote_interface_config, active_config;
  logic        local_bus_grant, tcu_wait, transfer_ack, local_bus_owner_n, bus_oe;
  logic        mem_write_n, instr_mem_write_n, high_instr_byte_flag, lock_out_remote;
  logic [15:0] instr_word, program_counter;
  logic [1:0]  memory_select_field;
  int          mismatches = 0;
  int          compares = 0;
  int          strobe_low = 0;
  int          istrobe_low = 0;
  int          s0;
  fast_buffered_remote_write dut (
    .clk_sys                 (clk_sys),
    .resetn                  (resetn),
    .remote_access_enable    (remote_access_enable),
    .remote_write_strobe_n   (remote_write_strobe_n),
    .cmd_select              (cmd_select),
    .wait_n                  (wait_n),
    .bus_lock_n              (bus_lock_n),
    .local_bus_request       (local_bus_request),
    .local_write_active      (local_write_active),
    .ad_in                   (ad_in),
    .device_config_reg       (device_config_reg),
    .local_bus_grant         (local_bus_grant),
    .tcu_wait                (tcu_wait),
    .transfer_ack            (transfer_ack),
    .local_bus_owner_n       (local_bus_owner_n),
    .bus_oe                  (bus_oe),
    .mem_write_n             (mem_write_n),
    .instr_mem_write_n       (instr_mem_write_n),
    .instr_word              (instr_word),
    .remote_interface_config (remote_interface_config),
    .active_config           (active_config),
    .program_counter         (program_counter),
    .high_instr_byte_flag    (high_instr_byte_flag),
    .memory_select_field     (memory_select_field),
    .lock_out_remote         (lock_out_remote)
  );
  fbw_remote_host host (
    .clk_sys               (clk_sys),
    .resetn                (resetn),
    .go                    (go),
    .cmd                   (cmd),
    .data                  (data),
    .ext                   (ext),
    .transfer_ack          (transfer_ack),
    .remote_access_enable  (remote_access_enable),
    .remote_write_strobe_n (remote_write_strobe_n),
    .cmd_select            (cmd_select),
    .ad_in                 (ad_in),
    .wait_n                (wait_n),
    .done                  (done)
  );
  initial begin
    clk_sys = 1'b0;
    forever #50 clk_sys = ~clk_sys;
  end
  always @(posedge clk_sys) if (mem_write_n === 1'b0) strobe_low <= strobe_low + 1;
  always @(posedge clk_sys) if (instr_mem_write_n === 1'b0) istrobe_low <= istrobe_low + 1;
  // ----------------------------------------
  // tasks
  // ----------------------------------------
  task automatic cyc(input int n);
    repeat (n) @(posedge clk_sys);
  endtask : cyc
  task automatic check_val(input logic [15:0] got, input logic [15:0] exp);
    compares++;
    if (got !== exp) begin
      mismatches++;
      $display("FAIL %0t value %h expected %h", $time, got, exp);
    end
  endtask : check_val
  task automatic check_bit(input logic got, input logic exp);
    compares++;
    if (got !== exp) begin
      mismatches++;
      $display("FAIL %0t flag %b expected %b", $time, got, exp);
    end
  endtask : check_bit
  task automatic write(input logic c, input logic [7:0] d, input logic [3:0] e);
    int n;
    @(posedge clk_sys);
    cmd <= c;
    data <= d;
    ext <= e;
    go <= 1'b1;
    n = 0;
    while (done !== 1'b1 && n < 300) begin
      @(posedge clk_sys);
      n++;
    end
    if (n >= 300) begin
      mismatches++;
      $display("FAIL %0t write not acknowledged", $time);
    end
    go <= 1'b0;
    cyc(8);
    @(negedge clk_sys);
  endtask : write
  task automatic conclude();
    $display("compares %0d mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : conclude
  initial begin
    #500000;
    mismatches++;
    $display("FAIL %0t watchdog expired", $time);
    conclude();
  end
  // ----------------------------------------
  // tests
  // ----------------------------------------
  initial begin
    cyc(8);
    resetn <= 1'b1;
    cyc(4);
    @(negedge clk_sys);
    check_bit(high_instr_byte_flag, 1'b0);
    @(posedge clk_sys);
    local_bus_request <= 1'b1;
    cyc(2);
    @(negedge clk_sys);
    check_bit(local_bus_grant, 1'b1);
    @(posedge clk_sys);
    bus_lock_n <= 1'b0;
    cyc(2);
    @(negedge clk_sys);
    check_bit(local_bus_grant, 1'b0);
    @(posedge clk_sys);
    bus_lock_n <= 1'b1;
    $display("test grant done");
    fork
      write(1'b1, 8'h02, 4'h0);
      begin
        cyc(10);
        @(negedge clk_sys);
        check_bit(transfer_ack, 1'b0);
        check_bit(local_bus_owner_n, 1'b0);
        @(posedge clk_sys);
        local_bus_request <= 1'b0;
        local_write_active <= 1'b1;
        cyc(2);
        local_write_active <= 1'b0;
      end
    join
    check_val({14'h0, memory_select_field}, 16'h0002);
    write(1'b0, 8'h34, 4'h0);
    write(1'b1, 8'h03, 4'h0);
    write(1'b0, 8'h12, 4'h0);
    check_val(program_counter, 16'h1234);
    $display("test counter done");
    write(1'b1, 8'h00, 4'h0);
    s0 = strobe_low;
    write(1'b0, 8'h5a, 4'h0);
    check_val(16'(strobe_low - s0), {13'h0, device_config_reg[2:0]} + 16'h1);
    s0 = strobe_low;
    fork
      write(1'b0, 8'ha5, 4'hf);
      begin
        cyc(10);
        local_bus_request <= 1'b1;
        cyc(2);
        @(negedge clk_sys);
        check_bit(local_bus_grant, 1'b0);
        check_bit(tcu_wait, 1'b1);
        @(posedge clk_sys);
        local_bus_request <= 1'b0;
      end
    join
    check_bit((strobe_low - s0) > 3, 1'b1);
    $display("test data memory done");
    write(1'b1, 8'h01, 4'h0);
    check_bit(high_instr_byte_flag, 1'b0);
    s0 = istrobe_low;
    write(1'b0, 8'hcd, 4'h0);
    check_bit(high_instr_byte_flag, 1'b1);
    check_val(16'(istrobe_low - s0), 16'h0000);
    s0 = istrobe_low;
    write(1'b0, 8'hab, 4'h0);
    check_val(16'(istrobe_low - s0), {14'h0, device_config_reg[4:3]} + 16'h2);
    check_val(instr_word, 16'habcd);
    check_val(program_counter, 16'h1235);
    check_bit(high_instr_byte_flag, 1'b0);
    write(1'b0, 8'h77, 4'h0);
    write(1'b1, 8'h01, 4'h0);
    check_bit(high_instr_byte_flag, 1'b0);
    write(1'b0, 8'h66, 4'h0);
    $display("test instruction memory done");
    write(1'b1, 8'h04, 4'h0);
    check_bit(lock_out_remote, 1'b1);
    check_val({8'h0, remote_interface_config}, 16'h0004);
    check_val({8'h0, active_config}, 16'h0004);
    @(posedge clk_sys);
    cmd <= 1'b0;
    go <= 1'b1;
    cyc(12);
    @(negedge clk_sys);
    check_bit(transfer_ack, 1'b0);
    check_bit(local_bus_owner_n, 1'b0);
    @(posedge clk_sys);
    go <= 1'b0;
    $display("test lock-out done");
    resetn <= 1'b0;
    cyc(4);
    resetn <= 1'b1;
    cyc(4);
    @(negedge clk_sys);
    check_bit(high_instr_byte_flag, 1'b0);
    check_bit(lock_out_remote, 1'b0);
    $display("test reset done");
    conclude();
  end
endmodule : test_fast_buffered_remote_write
`default_nettype wire
